// >>> src/sbr_pkg.sv
/*
  Package for the SMBus identification and block-read count register block.
  Holds register indices, field positions, reset values and the protocol
  state encodings shared by the protocol engine and the register bank.
  Assumes a single 50 MHz clock domain with SMBus pins sampled synchronously.
*/
package sbr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices as seen by the host.
  localparam logic [7:0] SBR_IDX_REV_VENDOR = 8'h05;
  localparam logic [7:0] SBR_IDX_DEV_TYPE = 8'h06;
  localparam logic [7:0] SBR_IDX_COUNT = 8'h07;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside the registers.
  localparam int SBR_REV_MSB = 7;
  localparam int SBR_REV_LSB = 4;
  localparam int SBR_VEND_MSB = 3;
  localparam int SBR_VEND_LSB = 0;
  localparam int SBR_TYPE_MSB = 7;
  localparam int SBR_TYPE_LSB = 6;
  localparam int SBR_PART_MSB = 5;
  localparam int SBR_PART_LSB = 0;
  localparam int SBR_CNT_MSB = 4;
  localparam int SBR_CNT_LSB = 0;
  localparam int SBR_RSVD_MSB = 7;
  localparam int SBR_RSVD_LSB = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and fixed codes.
  localparam logic [4:0] SBR_COUNT_RESET = 5'h08;
  localparam logic [2:0] SBR_RSVD_ZERO = 3'h0;
  localparam logic [1:0] SBR_TYPE_RESERVED = 2'h3;
  localparam logic [7:0] SBR_UNMAPPED_DATA = 8'h00;
  localparam logic [7:0] SBR_IDLE_BYTE = 8'hFF;
  localparam logic [7:0] SBR_INDEX_STEP = 8'h01;
  localparam logic [4:0] SBR_REMAIN_STEP = 5'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Target address: base value, with one bit taken from the strap pin.
  localparam logic [6:0] SBR_ADDR_BASE = 7'h68;
  localparam int SBR_ADDR_SEL_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Bit counting within a byte.
  localparam logic [3:0] SBR_BYTE_BITS = 4'h8;
  localparam logic [3:0] SBR_LAST_BIT = 4'h7;
  localparam logic [3:0] SBR_BIT_STEP = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol states and the meaning of a received byte.
  typedef enum logic [2:0] {
    SBR_ST_IDLE,
    SBR_ST_RX,
    SBR_ST_RX_ACK,
    SBR_ST_TX,
    SBR_ST_TX_ACK
  } sbr_state_type;

  typedef enum logic [1:0] {
    SBR_RK_ADDR,
    SBR_RK_CMD,
    SBR_RK_WCNT,
    SBR_RK_WDATA
  } sbr_rx_kind_type;

endpackage : sbr_pkg

// >>> src/sbr_reg_bank.sv
/*
  Register bank: read-only identification at indices 5 and 6 and the
  writable block-read count at index 7.
  Assumes the protocol engine presents one-cycle write strobes and a stable
  read index; indices outside 5 to 7 read as zero and ignore writes.
*/
module sbr_reg_bank
  import sbr_pkg::*;
#(
  parameter logic [3:0] REV_CODE = 4'h3,
  parameter logic [3:0] MAKER_CODE = 4'h5,
  parameter logic [1:0] CLASS_CODE = 2'h1,
  parameter logic [5:0] PART_CODE = 6'h15
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Write side.
  input wire logic wr_en_i,
  input wire logic [7:0] wr_index_i,
  input wire logic [7:0] wr_data_i,
  // Read side.
  input wire logic [7:0] rd_index_i,
  output logic [7:0] rd_data_o,
  output logic [4:0] count_o
);

  typedef struct packed {
    logic [4:0] count;
  } sbr_bank_state_type;

  localparam sbr_bank_state_type BANK_RESET = '{count: SBR_COUNT_RESET};

  sbr_bank_state_type bank_q;
  sbr_bank_state_type bank_d;

  ////////////////////////////////////////////////////////////////////////////
  // Only the low five bits of the count register store; the rest is dropped.
  always_comb
  begin
    bank_d = bank_q;
    if (wr_en_i && (wr_index_i == SBR_IDX_COUNT))
    begin
      bank_d.count = wr_data_i[SBR_CNT_MSB:SBR_CNT_LSB];
    end
  end

  // Count register, eight after reset.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      bank_q <= BANK_RESET;
    end
    else
    begin
      bank_q <= bank_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; identification codes are constants, so writes to them
  // have nowhere to land.
  always_comb
  begin
    case (rd_index_i)
      SBR_IDX_REV_VENDOR: rd_data_o = {REV_CODE, MAKER_CODE};
      SBR_IDX_DEV_TYPE: rd_data_o = {CLASS_CODE, PART_CODE};
      SBR_IDX_COUNT: rd_data_o = {SBR_RSVD_ZERO, bank_q.count};
      default: rd_data_o = SBR_UNMAPPED_DATA;
    endcase
  end

  assign count_o = bank_q.count;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the register contents.
  a_rev_code_fixed: assert property (@(posedge clk_i) disable iff (reset_i)
    (rd_index_i == SBR_IDX_REV_VENDOR) |-> (rd_data_o[SBR_REV_MSB:SBR_REV_LSB] == REV_CODE)
    ##1 (rd_index_i != SBR_IDX_REV_VENDOR || rd_data_o[SBR_REV_MSB:SBR_REV_LSB] == REV_CODE))
    else $error("Revision field changed or wrong.");

  a_maker_code_fixed: assert property (@(posedge clk_i) disable iff (reset_i)
    (rd_index_i == SBR_IDX_REV_VENDOR) |->
      (rd_data_o[SBR_VEND_MSB:SBR_VEND_LSB] == MAKER_CODE))
    else $error("Maker field wrong.");

  a_class_not_reserved: assert property (@(posedge clk_i) disable iff (reset_i)
    (rd_index_i == SBR_IDX_DEV_TYPE) |->
      (rd_data_o[SBR_TYPE_MSB:SBR_TYPE_LSB] == CLASS_CODE &&
       rd_data_o[SBR_TYPE_MSB:SBR_TYPE_LSB] != SBR_TYPE_RESERVED))
    else $error("Class field wrong or reserved.");

  a_part_code_fixed: assert property (@(posedge clk_i) disable iff (reset_i)
    (rd_index_i == SBR_IDX_DEV_TYPE) |->
      (rd_data_o[SBR_PART_MSB:SBR_PART_LSB] == PART_CODE))
    else $error("Part field wrong.");

  a_count_write_taken: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_en_i && wr_index_i == SBR_IDX_COUNT) |=>
      (count_o == $past(wr_data_i[SBR_CNT_MSB:SBR_CNT_LSB])))
    else $error("Count write not stored.");

  a_count_reset_eight: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(reset_i) |-> (count_o == SBR_COUNT_RESET))
    else $error("Count not eight after reset.");

  a_count_upper_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    (rd_index_i == SBR_IDX_COUNT) |->
      (rd_data_o[SBR_RSVD_MSB:SBR_RSVD_LSB] == SBR_RSVD_ZERO))
    else $error("Reserved count bits not zero.");

endmodule : sbr_reg_bank

// >>> src/sbr_top.sv
/*
  SMBus target engine with the identification and block-read count
  registers: indexed block writes and indexed block reads.
  Assumes SCL and SDA are already synchronous to clk_i and change far slower
  than the clock; SDA is open drain and resolved outside from sda_oe_o.
*/
// Operation
// - The upper nibble of index 5 shows a fixed revision code that writes cannot change.
// - The lower nibble of index 5 shows a fixed maker code that writes cannot change.
// - The top two bits of index 6 show a fixed class code that is never the reserved 11.
// - The low six bits of index 6 show a fixed part code.
// - The low five bits of index 7 are writable and set how many data bytes a block read returns.
// - After reset the count at index 7 holds eight.
// - A block read first returns the count, then the bytes from index N up to N+X-1.
module sbr_top
  import sbr_pkg::*;
#(
  parameter logic [3:0] REV_CODE = 4'h3, // Arbitrary value.
  parameter logic [3:0] MAKER_CODE = 4'h5, // Arbitrary value.
  parameter logic [1:0] CLASS_CODE = 2'h1, // Arbitrary value.
  parameter logic [5:0] PART_CODE = 6'h15 // Arbitrary value.
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Address strap.
  input wire logic sadr_i,
  // SMBus pins.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);

  typedef struct packed {
    sbr_state_type st;
    sbr_rx_kind_type kind;
    logic rd_mode;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] index;
    logic [4:0] remain;
    logic nack;
    logic scl_prev;
    logic sda_prev;
    logic strap_done;
    logic [6:0] own_addr;
    logic oe;
    logic sda_out;
  } sbr_ctl_type;

  sbr_ctl_type q;
  sbr_ctl_type d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic bank_wr_en;
  logic [7:0] bank_rd_data;
  logic [4:0] bank_count;

  ////////////////////////////////////////////////////////////////////////////
  // Register bank, read at the current index and written at the same index.
  sbr_reg_bank #(
    .REV_CODE(REV_CODE),
    .MAKER_CODE(MAKER_CODE),
    .CLASS_CODE(CLASS_CODE),
    .PART_CODE(PART_CODE)
  ) u_bank (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .wr_en_i(bank_wr_en),
    .wr_index_i(q.index),
    .wr_data_i(q.sh),
    .rd_index_i(q.index),
    .rd_data_o(bank_rd_data),
    .count_o(bank_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions. A start or stop is only legal while SCL stays high, so
  // our own SDA changes, made while SCL is low, never look like one.
  always_comb
  begin
    scl_rise = scl_i && !q.scl_prev;
    scl_fall = !scl_i && q.scl_prev;
    start_seen = scl_i && q.scl_prev && q.sda_prev && !sda_i;
    stop_seen = scl_i && q.scl_prev && !q.sda_prev && sda_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine. Received bits are sampled on SCL rising; our own bits
  // and acknowledges change on SCL falling, so they are stable while high.
  always_comb
  begin
    d = q;
    bank_wr_en = 1'b0;
    d.scl_prev = scl_i;
    d.sda_prev = sda_i;
    // The strap is caught once, on the first clock after reset is released.
    if (!q.strap_done)
    begin
      d.strap_done = 1'b1;
      d.own_addr = SBR_ADDR_BASE;
      d.own_addr[SBR_ADDR_SEL_BIT] = sadr_i;
    end
    if (stop_seen)
    begin
      d.st = SBR_ST_IDLE;
      d.oe = 1'b0;
    end
    else if (start_seen)
    begin
      // A repeated start keeps the index set by the preceding command byte.
      d.st = SBR_ST_RX;
      d.kind = SBR_RK_ADDR;
      d.rd_mode = 1'b0;
      d.cnt = '0;
      d.oe = 1'b0;
    end
    else
    begin
      case (q.st)
        SBR_ST_IDLE:
        begin
          d.oe = 1'b0;
        end
        SBR_ST_RX:
        begin
          if (scl_rise)
          begin
            d.sh = {q.sh[6:0], sda_i};
            d.cnt = q.cnt + SBR_BIT_STEP;
          end
          else if (scl_fall && q.cnt == SBR_BYTE_BITS)
          begin
            d.cnt = '0;
            d.st = SBR_ST_RX_ACK;
            d.oe = 1'b1;
            case (q.kind)
              SBR_RK_ADDR:
              begin
                if (q.sh[7:1] == q.own_addr)
                begin
                  d.rd_mode = q.sh[0];
                  d.kind = SBR_RK_CMD;
                end
                else
                begin
                  // Not our address: stay off the bus until the next start.
                  d.st = SBR_ST_IDLE;
                  d.oe = 1'b0;
                end
              end
              SBR_RK_CMD:
              begin
                d.index = q.sh;
                d.kind = SBR_RK_WCNT;
              end
              SBR_RK_WCNT:
              begin
                // The host's byte count is acknowledged but not needed.
                d.kind = SBR_RK_WDATA;
              end
              SBR_RK_WDATA:
              begin
                bank_wr_en = 1'b1;
                d.index = q.index + SBR_INDEX_STEP;
              end
              default:
              begin
                d.st = SBR_ST_IDLE;
                d.oe = 1'b0;
              end
            endcase
          end
        end
        SBR_ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            if (q.rd_mode)
            begin
              // Read direction: the count goes out before any data byte.
              d.st = SBR_ST_TX;
              d.sh = {SBR_RSVD_ZERO, bank_count};
              d.remain = bank_count;
              d.cnt = '0;
              d.oe = !d.sh[7];
            end
            else
            begin
              d.st = SBR_ST_RX;
              d.oe = 1'b0;
            end
          end
        end
        SBR_ST_TX:
        begin
          if (scl_fall)
          begin
            if (q.cnt == SBR_LAST_BIT)
            begin
              d.st = SBR_ST_TX_ACK;
              d.cnt = '0;
              d.oe = 1'b0;
            end
            else
            begin
              d.sh = {q.sh[6:0], 1'b0};
              d.cnt = q.cnt + SBR_BIT_STEP;
              d.oe = !q.sh[6];
            end
          end
        end
        SBR_ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            d.nack = sda_i;
          end
          else if (scl_fall)
          begin
            if (q.nack)
            begin
              // Not-acknowledge ends the read; wait for the stop.
              d.st = SBR_ST_IDLE;
              d.oe = 1'b0;
            end
            else
            begin
              // Past the count the line is left released, so a host that
              // reads on sees all ones rather than stale registers.
              if (q.remain != '0)
              begin
                d.sh = bank_rd_data;
                d.index = q.index + SBR_INDEX_STEP;
                d.remain = q.remain - SBR_REMAIN_STEP;
              end
              else
              begin
                d.sh = SBR_IDLE_BYTE;
              end
              d.st = SBR_ST_TX;
              d.cnt = '0;
              d.oe = !d.sh[7];
            end
          end
        end
        default:
        begin
          d.st = SBR_ST_IDLE;
          d.oe = 1'b0;
        end
      endcase
    end
  end

  // State register; the whole engine clears to idle with the line released.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Open drain: the pin only ever pulls low, so the data bit stays zero.
  assign sda_o = q.sda_out;
  assign sda_oe_o = q.oe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the read sequence.
  a_count_goes_first: assert property (@(posedge clk_i) disable iff (reset_i)
    (q.st == SBR_ST_RX_ACK && q.rd_mode && scl_fall) |=>
      (q.st == SBR_ST_TX && q.sh == {SBR_RSVD_ZERO, $past(bank_count)} &&
       q.remain == $past(bank_count)))
    else $error("Block read did not start with the count.");

  a_data_in_order: assert property (@(posedge clk_i) disable iff (reset_i)
    (q.st == SBR_ST_TX_ACK && scl_fall && !q.nack && q.remain != '0) |=>
      (q.sh == $past(bank_rd_data) && q.index == $past(q.index) + SBR_INDEX_STEP))
    else $error("Data byte not taken from the next index.");

  a_len_from_count: assert property (@(posedge clk_i) disable iff (reset_i)
    (q.st == SBR_ST_TX_ACK && scl_fall && !q.nack && q.remain == '0) |=>
      (q.sh == SBR_IDLE_BYTE && q.oe == 1'b0))
    else $error("Byte sent beyond the programmed count.");

  a_nack_releases: assert property (@(posedge clk_i) disable iff (reset_i)
    (q.st == SBR_ST_TX_ACK && scl_fall && q.nack && !start_seen) |=>
      (q.st == SBR_ST_IDLE && !sda_oe_o))
    else $error("Line still driven after not-acknowledge.");

endmodule : sbr_top

// >>> testbench/sbr_host_model.sv
/*
  Behavioural SMBus host that drives SCL and pulls SDA low for the bench.
  Assumes the bench resolves SDA as a pulled-up wire from every pull-down.
*/
module sbr_host_model
(
  // Clock and resolved data line.
  input wire logic clk_i,
  input wire logic sda_i,
  // Host drives.
  output logic scl_o,
  output logic sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clock cycles per SCL phase, far slower than the device clock.
  localparam int HALF = 5;

  // SCL idles high and SDA is released, as on an idle bus.
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Bit level.
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : wait_clk

  // SDA only moves while SCL is low, so no false start or stop is seen.
  task automatic bit_c(input logic b, output logic seen);
    sda_oe_o = !b;
    wait_clk(HALF);
    scl_o = 1'b1;
    wait_clk(HALF);
    seen = sda_i;
    scl_o = 1'b0;
    wait_clk(1);
  endtask : bit_c

  task automatic start_c;
    sda_oe_o = 1'b0;
    wait_clk(HALF);
    scl_o = 1'b1;
    wait_clk(HALF);
    sda_oe_o = 1'b1;
    wait_clk(HALF);
    scl_o = 1'b0;
    wait_clk(HALF);
  endtask : start_c

  task automatic stop_c;
    sda_oe_o = 1'b1;
    wait_clk(HALF);
    scl_o = 1'b1;
    wait_clk(HALF);
    sda_oe_o = 1'b0;
    wait_clk(HALF);
  endtask : stop_c

  //////////////////////////////////////////////////////////////////////////
  // Byte level, most significant bit first.
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_c(b[i], s);
    end
    bit_c(1'b1, s);
    ack = !s;
  endtask : write_byte

  // Every byte is acknowledged except the last, which gets a not-acknowledge.
  task automatic read_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_c(1'b1, s);
      b[i] = s;
    end
    bit_c(nack, s);
  endtask : read_byte

endmodule : sbr_host_model

// >>> testbench/sbr_top_tb.sv
/*
  Self-checking bench for the identification and block-read count registers.
  Assumes the host model as bus partner and a pull-up on SDA.
*/
module sbr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbr_pkg::*;

  // Identification values for this run.
  localparam logic [3:0] REV = 4'hA; // Arbitrary value.
  localparam logic [3:0] MAKER = 4'h6; // Arbitrary value.
  localparam logic [1:0] CLASS = 2'h2; // Arbitrary value.
  localparam logic [5:0] PART = 6'h2C; // Arbitrary value.
  localparam logic [6:0] ADDR0 = SBR_ADDR_BASE;
  localparam logic [6:0] ADDR1 = SBR_ADDR_BASE | 7'h02;

  logic clk_i;
  logic reset_i;
  logic sadr_i;
  logic scl_w;
  logic host_oe;
  logic dev_sda;
  logic dev_oe;
  logic sda_w;
  logic ack;
  logic [7:0] got [0:40];
  int error_cnt;
  int tests_run;

  // Open-drain wire: low while any party pulls, else pulled up.
  assign sda_w = !(dev_oe | host_oe);

  sbr_top #(.REV_CODE(REV), .MAKER_CODE(MAKER), .CLASS_CODE(CLASS), .PART_CODE(PART)) u_dut
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sadr_i(sadr_i),
    .scl_i(scl_w),
    .sda_i(sda_w),
    .sda_o(dev_sda),
    .sda_oe_o(dev_oe)
  );

  sbr_host_model u_host
  (
    .clk_i(clk_i),
    .sda_i(sda_w),
    .scl_o(scl_w),
    .sda_oe_o(host_oe)
  );

  // Free-running 50 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  //////////////////////////////////////////////////////////////////////////
  // Shared tasks.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  // The strap is only caught after release, so it is set before.
  task automatic do_reset(input logic strap);
    sadr_i = strap;
    reset_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #2;
    reset_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #2;
  endtask : do_reset

  task automatic send_addr(input logic [7:0] b, input logic exp_ack);
    u_host.write_byte(b, ack);
    check({7'h00, ack}, {7'h00, exp_ack});
  endtask : send_addr

  // Indexed block write of n bytes, high byte of data first.
  task automatic blk_write(input logic [7:0] idx, input logic [15:0] data, input int n);
    u_host.start_c();
    send_addr({ADDR0, 1'b0}, 1'b1);
    send_addr(idx, 1'b1);
    send_addr(8'(n), 1'b1);
    for (int i = 0; i < n; i++)
    begin
      send_addr(data[15 - 8 * i -: 8], 1'b1);
    end
    u_host.stop_c();
  endtask : blk_write

  // Indexed block read of n bytes, count byte included, into got.
  task automatic blk_read(input logic [6:0] a, input logic [7:0] idx, input int n);
    u_host.start_c();
    send_addr({a, 1'b0}, 1'b1);
    send_addr(idx, 1'b1);
    u_host.start_c();
    send_addr({a, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      u_host.read_byte(i == n - 1, got[i]);
    end
    u_host.stop_c();
  endtask : blk_read

  //////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset_vals;
    blk_read(ADDR0, SBR_IDX_REV_VENDOR, 10);
    check(got[0], 8'h08);
    check({4'h0, got[1][7:4]}, {4'h0, REV});
    check({4'h0, got[1][3:0]}, {4'h0, MAKER});
    check({6'h00, got[2][7:6]}, {6'h00, CLASS});
    check({2'h0, got[2][5:0]}, {2'h0, PART});
    check(got[3], 8'h08);
    for (int i = 4; i < 9; i++)
    begin
      check(got[i], 8'h00);
    end
    check(got[9], 8'hFF);
  endtask : t_reset_vals

  // Identification writes are dropped; reserved count bits read zero.
  task automatic t_ro_writes;
    blk_write(SBR_IDX_REV_VENDOR, 16'hFFFF, 2);
    blk_write(SBR_IDX_COUNT, 16'hE300, 1);
    blk_read(ADDR0, SBR_IDX_REV_VENDOR, 5);
    check(got[0], 8'h03);
    check(got[1], {REV, MAKER});
    check(got[2], {CLASS, PART});
    check(got[3], 8'h03);
    check(got[4], 8'hFF);
  endtask : t_ro_writes

  // Largest and smallest counts.
  task automatic t_count_edges;
    blk_write(SBR_IDX_COUNT, 16'h1F00, 1);
    blk_read(ADDR0, SBR_IDX_COUNT, 33);
    check(got[0], 8'h1F);
    check(got[1], 8'h1F);
    for (int i = 2; i < 32; i++)
    begin
      check(got[i], 8'h00);
    end
    check(got[32], 8'hFF);
    blk_write(SBR_IDX_COUNT, 16'h0000, 1);
    blk_read(ADDR0, SBR_IDX_COUNT, 2);
    check(got[0], 8'h00);
    check(got[1], 8'hFF);
  endtask : t_count_edges

  // Foreign address refused; a reset in mid-run restores the count.
  task automatic t_addr_strap;
    u_host.start_c();
    send_addr({ADDR1, 1'b0}, 1'b0);
    u_host.stop_c();
    do_reset(1'b1);
    u_host.start_c();
    send_addr({ADDR0, 1'b0}, 1'b0);
    u_host.stop_c();
    blk_read(ADDR1, SBR_IDX_COUNT, 2);
    check(got[0], 8'h08);
    check(got[1], 8'h08);
    check({7'h00, dev_sda}, 8'h00);
  endtask : t_addr_strap

  //////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog.
  initial
  begin
    error_cnt = 0;
    tests_run = 0;
    reset_i = 1'b1;
    sadr_i = 1'b0;
    #2;
    do_reset(1'b0);
    t_reset_vals();
    t_ro_writes();
    t_count_edges();
    t_addr_strap();
    close_out();
  end

  // The whole run needs some 9000 cycles; a hang is cut off well beyond.
  initial
  begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    close_out();
  end

endmodule : sbr_top_tb
